// [logic/light_timing_defs.svh]
// Register map, field positions, reset values and timing counts
`ifndef LIGHT_TIMING_DEFS_SVH
`define LIGHT_TIMING_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_FUNCTION_ENABLE    8'h80
`define OFS_INTEGRATION_LENGTH 8'h81
`define OFS_WAIT_LENGTH        8'h83
`define OFS_CONFIG_ZERO        8'h8D

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define BIT_POWER_ON           0
`define BIT_MEASURE_ENABLE     1
`define BIT_WAIT_ENABLE        3
`define BIT_LONG_WAIT          2
`define RST_FUNCTION_ENABLE    8'h00
`define RST_INTEGRATION_LENGTH 8'h00
`define RST_WAIT_LENGTH        8'h00
`define RST_CONFIG_ZERO        8'h80

// ----------------------------------------
// Timing
// ----------------------------------------
`define OSC_DIVIDE             4'hB
`define STEP_TICKS             11'h7FF
`define LONG_WAIT_FACTOR       4'hC
`define FULL_SCALE_PER_STEP    19'h00400
`define FULL_SCALE_MAX         16'hFFFF

`endif

// [logic/light_timing_pkg.sv]
// Types shared by the light sensor enable and timing block
package light_timing_pkg;

  typedef enum logic [1:0] {
    st_sleep     = 2'b00,
    st_idle      = 2'b01,
    st_integrate = 2'b10,
    st_wait      = 2'b11
  } phase_type;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

endpackage

// [logic/light_timing.sv]
// Power, enable and integration/wait timing of an ambient light sensor
`timescale 1ns/1ps
`include "light_timing_defs.svh"

module light_timing
  import light_timing_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire reg_req_type reg_req,
  output logic [7:0]       reg_rdata,
  output logic             osc_enable,
  output logic             converter_enable,
  output logic             integrating,
  output logic             integration_done,
  output logic [15:0]      full_scale,
  output logic [1:0]       phase
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // One-hot select of the four stored registers; unmapped offsets give zero
  function automatic logic [3:0] reg_sel(input logic [7:0] addr);
    case (addr)
      `OFS_FUNCTION_ENABLE:    reg_sel = 4'h1;
      `OFS_INTEGRATION_LENGTH: reg_sel = 4'h2;
      `OFS_WAIT_LENGTH:        reg_sel = 4'h4;
      `OFS_CONFIG_ZERO:        reg_sel = 4'h8;
      default:                 reg_sel = 4'h0;
    endcase
  endfunction

  // Both timed phases share the step divider and the down counter
  function automatic logic is_timed(input phase_type p);
    is_timed = (p == st_integrate) || (p == st_wait);
  endfunction

  // Full scale is one count short of a whole number of 1024 blocks.
  // The product is kept wide enough for 256 steps so that it cannot wrap
  // back below the saturation limit.
  function automatic logic [15:0] scale_of(input logic [7:0] len);
    logic [18:0] prod;
    prod = ({11'h000, len} + 19'h00001) * `FULL_SCALE_PER_STEP
           - 19'h00001;
    scale_of = (prod > {3'h0, `FULL_SCALE_MAX}) ? `FULL_SCALE_MAX
                                                 : prod[15:0];
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] function_enable_r;
  logic [7:0] integration_length_r;
  logic [7:0] wait_length_r;
  logic [7:0] config_zero_r;
  logic [3:0] wr_sel;
  logic [3:0] rd_sel;

  assign wr_sel = reg_req.write ? reg_sel(reg_req.addr) : 4'h0;
  assign rd_sel = reg_sel(reg_req.addr);

  // Every bit is stored as written, reserved ones included, so a read
  // returns what the host last wrote
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      function_enable_r <= `RST_FUNCTION_ENABLE;
    end else if (wr_sel[0]) begin
      function_enable_r <= reg_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      integration_length_r <= `RST_INTEGRATION_LENGTH;
    end else if (wr_sel[1]) begin
      integration_length_r <= reg_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wait_length_r <= `RST_WAIT_LENGTH;
    end else if (wr_sel[2]) begin
      wait_length_r <= reg_req.wdata;
    end
  end

  // Only the long-wait bit acts; the reserved bits are merely kept
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      config_zero_r <= `RST_CONFIG_ZERO;
    end else if (wr_sel[3]) begin
      config_zero_r <= reg_req.wdata;
    end
  end

  // Read data stands until the next read strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.read) begin
      case (rd_sel)
        4'h1:    reg_rdata <= function_enable_r;
        4'h2:    reg_rdata <= integration_length_r;
        4'h4:    reg_rdata <= wait_length_r;
        4'h8:    reg_rdata <= config_zero_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Enable decode
  // ----------------------------------------
  // Register changes act at once; a host that changes lengths while
  // measuring gets them on the next phase load
  logic power_on_bit;
  logic light_measure_enable;
  logic wait_enable;
  logic long_wait_multiplier;

  assign power_on_bit         = function_enable_r[`BIT_POWER_ON];
  assign light_measure_enable = function_enable_r[`BIT_MEASURE_ENABLE];
  assign wait_enable          = function_enable_r[`BIT_WAIT_ENABLE];
  assign long_wait_multiplier = config_zero_r[`BIT_LONG_WAIT];

  // ----------------------------------------
  // Phase sequencer
  // ----------------------------------------
  // Sleep, idle, then integrate and wait in turn while measuring is on
  phase_type  state_r;
  phase_type  state_nxt;
  logic       step_tick;
  logic       step_end;
  logic [7:0] step_cnt_r;
  logic [3:0] long_cnt_r;
  logic       long_wrap;
  logic       integ_last;
  logic       wait_last;

  // A wait step only counts down once all its long-wait ticks are spent
  assign long_wrap  = !long_wait_multiplier ||
                      (long_cnt_r == `LONG_WAIT_FACTOR - 4'h1);
  // Integration ends on the step that finishes with the counter at zero
  assign integ_last = step_tick && (step_cnt_r == 8'h00);
  assign wait_last  = step_tick && (step_cnt_r == 8'h00) && long_wrap;
  assign step_end   = (state_r == st_integrate) ? integ_last : wait_last;

  // Power and enable are applied after the case so they win over a step end
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_sleep: begin
        if (power_on_bit) state_nxt = st_idle;
      end
      st_idle: begin
        if (light_measure_enable) state_nxt = st_integrate;
      end
      st_integrate: begin
        if (step_end) state_nxt = wait_enable ? st_wait : st_integrate;
      end
      st_wait: begin
        if (step_end) state_nxt = st_integrate;
      end
      default: begin
        state_nxt = st_sleep;
      end
    endcase
    if (!power_on_bit) begin
      state_nxt = st_sleep;
    end else if (!light_measure_enable && state_r != st_sleep) begin
      state_nxt = st_idle;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= st_sleep;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Integration clock and step divider
  // ----------------------------------------
  // Divider only runs in a timed phase so sleep and idle draw no toggles.
  // A phase change restarts both counters, so every phase is made of
  // whole steps of eleven times 2048 clocks.
  logic [3:0]  osc_div_r;
  logic [10:0] tick_cnt_r;
  logic        integ_clk_en;
  logic        running;

  assign running      = is_timed(state_r);
  assign integ_clk_en = (osc_div_r == `OSC_DIVIDE - 4'h1);
  assign step_tick    = integ_clk_en && (tick_cnt_r == `STEP_TICKS);

  always_ff @(posedge ref_clk) begin
    if (reset || !running || state_nxt != state_r) begin
      osc_div_r <= 4'h0;
    end else if (integ_clk_en) begin
      osc_div_r <= 4'h0;
    end else begin
      osc_div_r <= osc_div_r + 4'h1;
    end
  end

  // Wraps by itself at the end of a step, ready for the next one
  always_ff @(posedge ref_clk) begin
    if (reset || !running || state_nxt != state_r) begin
      tick_cnt_r <= 11'h000;
    end else if (integ_clk_en) begin
      tick_cnt_r <= tick_cnt_r + 11'h001;
    end
  end

  // ----------------------------------------
  // Step down counters
  // ----------------------------------------
  // Loaded on entry to each phase, back-to-back integrations included.
  // Long-wait steps take twelve step ticks for one decrement.
  logic phase_load;
  logic step_dec;

  assign phase_load = (state_nxt != state_r) || (running && step_end);
  assign step_dec   = step_tick &&
                      ((state_r == st_integrate) ||
                       (state_r == st_wait && long_wrap));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      step_cnt_r <= 8'h00;
    end else if (phase_load) begin
      step_cnt_r <= (state_nxt == st_wait) ? wait_length_r
                                           : integration_length_r;
    end else if (step_dec) begin
      step_cnt_r <= step_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || phase_load) begin
      long_cnt_r <= 4'h0;
    end else if (state_r == st_wait && step_tick) begin
      if (long_wrap) begin
        long_cnt_r <= 4'h0;
      end else begin
        long_cnt_r <= long_cnt_r + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Oscillator and converters follow the power bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      osc_enable       <= 1'b0;
      converter_enable <= 1'b0;
    end else begin
      osc_enable       <= power_on_bit;
      converter_enable <= power_on_bit;
    end
  end

  // Built from the next state so they line up with state_r
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      integrating <= 1'b0;
      phase       <= 2'b00;
    end else begin
      integrating <= (state_nxt == st_integrate);
      phase       <= state_nxt;
    end
  end

  // One pulse on the edge that leaves the last integration step
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      integration_done <= 1'b0;
    end else begin
      integration_done <= (state_r == st_integrate) && step_end;
    end
  end

  // A new length shows here two edges after its write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      full_scale <= 16'h0000;
    end else begin
      full_scale <= scale_of(integration_length_r);
    end
  end

endmodule

// [test/light_timing_sva.sv]
// Concurrent checks on the ports of the light sensor timing block
`timescale 1ns/1ps
module light_timing_sva
  import light_timing_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire reg_req_type reg_req,
  input wire logic [7:0]  reg_rdata,
  input wire logic        osc_enable,
  input wire logic        converter_enable,
  input wire logic        integrating,
  input wire logic        integration_done,
  input wire logic [15:0] full_scale,
  input wire logic [1:0]  phase
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [7:0]  len_r;
  logic [31:0] run_r;
  // Shadow of the integration length, loaded on the same edge as the design
  always_ff @(posedge ref_clk) begin
    if (reset) len_r <= 8'h00;
    else if (reg_req.write && reg_req.addr == 8'h81) len_r <= reg_req.wdata;
  end
  // Cycles spent integrating, still held one cycle after the phase ends
  always_ff @(posedge ref_clk) begin
    if (reset || !integrating) run_r <= 32'h0;
    else run_r <= run_r + 32'h1;
  end
  chk_conv_follow: assert property (converter_enable == osc_enable)
    else $error("converter enable differs from oscillator enable");
  chk_power_sleep: assert property (
    $fell(osc_enable) |-> ##[0:1] phase == st_sleep)
    else $error("no sleep after power bit cleared");
  chk_power_wake: assert property (
    $rose(osc_enable) |-> ##[0:2] phase != st_sleep)
    else $error("still asleep after power bit set");
  chk_integ_flag: assert property (
    integrating == (phase == st_integrate))
    else $error("integrating flag disagrees with phase");
  chk_done_single: assert property (
    integration_done |=> !integration_done)
    else $error("integration done longer than one cycle");
  chk_done_after: assert property (
    integration_done |-> $past(integrating))
    else $error("integration done outside integration");
  chk_done_end: assert property (
    $fell(integrating) && phase == st_wait |-> ##[0:1] integration_done)
    else $error("integration ended without done pulse");
  chk_step_count: assert property (
    $fell(integrating) && phase == st_wait |->
      run_r == 32'h5800 * ({24'h0, len_r} + 32'h1))
    else $error("integration length wrong");
  chk_full_scale: assert property (
    reg_req.write && reg_req.addr == 8'h81 |=> ##1 full_scale ==
      ((len_r >= 8'h3F) ? 16'hFFFF : {len_r[5:0], 10'h3FF}))
    else $error("full scale wrong");
endmodule

bind light_timing light_timing_sva chk_u (
  .ref_clk(ref_clk), .reset(reset), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .osc_enable(osc_enable),
  .converter_enable(converter_enable), .integrating(integrating),
  .integration_done(integration_done), .full_scale(full_scale),
  .phase(phase));

// [test/light_timing_tb.sv]
// Self-checking bench for the light sensor timing block
`timescale 1ns/1ps
module light_timing_tb;
  import light_timing_pkg::*;
  logic        ref_clk, reset, osc_enable, converter_enable;
  logic        integrating, integration_done;
  reg_req_type reg_req;
  logic [7:0]  reg_rdata, v;
  logic [15:0] full_scale;
  logic [1:0]  phase;
  logic [7:0]  exp_q[$];
  int          n_mismatch, n_tests, n_done, n;
  light_timing dut_u (.ref_clk, .reset, .reg_req, .reg_rdata, .osc_enable,
    .converter_enable, .integrating, .integration_done, .full_scale, .phase);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask
  // Read data is registered on the edge that takes the strobe and checked at the next falling edge
  always @(posedge ref_clk) begin
    if (reg_req.read === 1'b1) begin
      @(negedge ref_clk);
      check(reg_rdata === exp_q.pop_front(), "read data");
    end
  end
  always @(posedge ref_clk) if (integration_done === 1'b1) n_done++;
  // Steps up to the first sampled edge of the wanted phase
  task automatic await_phase(input logic [1:0] p);
    int k;
    k = 0;
    while (phase !== p && k < 10) begin
      k++;
      @(posedge ref_clk);
    end
  endtask
  // Counts sampled edges while the phase holds
  task automatic count_phase(input logic [1:0] p, output int c);
    c = 0;
    while (phase === p && c < 30000) begin
      c++;
      @(posedge ref_clk);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    reg_req = '0;
    v = 8'($urandom(16489));
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rd(8'h80, 8'h00);
    rd(8'h81, 8'h00);
    rd(8'h83, 8'h00);
    rd(8'h8D, 8'h80);
    rd(8'h84, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = (i < 2) ? 8'h3E + 8'(i) : 8'($urandom);
      wr(8'h81, v);
      rd(8'h81, v);
      check(full_scale === ((v > 8'h3E) ? 16'hFFFF
        : 16'(1024 * (v + 1) - 1)), "full scale");
    end
    v = 8'($urandom);
    wr(8'h83, v);
    rd(8'h83, v);
    wr(8'h83, 8'h00);
    wr(8'h8D, 8'h84);
    rd(8'h8D, 8'h84);
    wr(8'h8D, 8'h80);
    wr(8'h81, 8'h00);
    wr(8'h80, 8'h09);
    repeat (4) @(posedge ref_clk);
    check(phase === st_idle && osc_enable === 1'b1, "idle");
    wr(8'h80, 8'h0B);
    await_phase(st_integrate);
    count_phase(st_integrate, n);
    check(n == 22528, "integration length");
    check(phase === st_wait, "wait entered");
    count_phase(st_wait, n);
    check(n == 22528, "wait length");
    check(phase === st_integrate && n_done == 1, "cycle repeat");
    wr(8'h80, 8'h09);
    wr(8'h8D, 8'h84);
    wr(8'h80, 8'h0B);
    await_phase(st_integrate);
    count_phase(st_integrate, n);
    check(n == 22528 && phase === st_wait, "second integration");
    // A plain one-step wait of 22528 cycles would be over just before this
    repeat (23000) @(posedge ref_clk);
    check(phase === st_wait, "long wait");
    wr(8'h80, 8'h00);
    repeat (3) @(posedge ref_clk);
    check(phase === st_sleep && osc_enable === 1'b0 &&
      converter_enable === 1'b0, "sleep");
    wrap_up();
  end
  // Whole run needs about 91000 cycles
  initial begin
    #5000000;
    n_mismatch++;
    wrap_up();
  end
endmodule
